// ===== hw/dfm_defines.svh
`ifndef DFM_DEFINES_SVH
`define DFM_DEFINES_SVH

// Register indices; byte address is four times the index
`define DFM_IDX_UV_STATUS     12'h01c
`define DFM_IDX_UV_MASK       12'h024
`define DFM_IDX_ACTIVE_OPTS   12'h0b1
`define DFM_IDX_CONV1_CTRL    12'h0b5
`define DFM_IDX_CONV2_CTRL    12'h0b8
`define DFM_IDX_CONV3_CTRL    12'h0bb
`define DFM_IDX_CONV4_CTRL    12'h0be
`define DFM_IDX_PIN_MASK      12'h0d7

// Field positions
`define DFM_BLANK_SEL_HI      13
`define DFM_BLANK_SEL_LO      12
`define DFM_ACTION_HI         15
`define DFM_ACTION_LO         14

// Reset values
`define DFM_RST_UV_MASK       4'h0
`define DFM_RST_PIN_MASK      4'h0
`define DFM_RST_BLANK_SEL     2'h0
`define DFM_RST_ACTION        2'h0

// Undervoltage threshold as a percentage of target
`define DFM_UV_PCT            95
`define DFM_FULL_PCT          100

// Timing: clock rate and blanking times in microseconds
`define DFM_CLK_MHZ           125
`define DFM_BLANK0_US         500
`define DFM_BLANK1_US         2000
`define DFM_BLANK2_US         32000
`define DFM_BLANK3_US         256000
`define DFM_FILTER_CYCLES     16

`endif

// ===== hw/dfm_pkg.sv
package dfm_pkg;

   // Fault response selected per converter
   typedef enum logic [1:0] {
      DFM_ACT_IGNORE,
      DFM_ACT_CONV_OFF,
      DFM_ACT_SYS_OFF,
      DFM_ACT_SYS_OFF_RSVD
   } dfm_action_e;

   typedef logic [11:0] dfm_addr_t;

endpackage

// ===== hw/dfm_fault_monitor.sv
`timescale 1ns/10ps
`include "dfm_defines.svh"

module dfm_fault_monitor
   import dfm_pkg::*;
#(
   parameter int unsigned LVL_W         = 8,
   parameter int unsigned FILTER_CYCLES = `DFM_FILTER_CYCLES,
   parameter int unsigned BLANK_CYC0    = `DFM_BLANK0_US * `DFM_CLK_MHZ,
   parameter int unsigned BLANK_CYC1    = `DFM_BLANK1_US * `DFM_CLK_MHZ,
   parameter int unsigned BLANK_CYC2    = `DFM_BLANK2_US * `DFM_CLK_MHZ,
   parameter int unsigned BLANK_CYC3    = `DFM_BLANK3_US * `DFM_CLK_MHZ
) (
   input  wire logic                       ref_clk,           // System clock
   input  wire logic                       sys_rst,           // Sync reset, high
   input  wire dfm_addr_t                  paddr,             // APB address
   input  wire logic                       psel,              // APB select
   input  wire logic                       penable,           // APB enable
   input  wire logic                       pwrite,            // APB direction
   input  wire logic [31:0]                pwdata,            // APB write data
   output logic      [31:0]                prdata,            // APB read data
   output logic                            pready,            // APB ready
   output logic                            pslverr,           // APB error
   input  wire logic [3:0][LVL_W-1:0]      convMeasLevel,     // Measured outputs
   input  wire logic [3:0][LVL_W-1:0]      convTargetLevel,   // Programmed targets
   input  wire logic [3:0]                 convOverVoltAsync, // Analog overvoltage
   input  wire logic [3:0]                 convEnableReq,     // Sequencer enables
   input  wire logic                       ldoUndervoltIrq,   // LDO second-level irq
   input  wire logic                       ldoFault,          // Any LDO fault
   input  wire logic                       climFault,         // Current-limit fault
   input  wire logic                       faultPinAssign,    // GPIO given to pin
   output logic      [3:0]                 convEnable,        // Converter enables
   output logic                            sysShutdownReq,    // System shutdown
   output logic                            supplyUndervoltIrq,// First-level irq
   output logic                            supplyFaultN,      // Fault pin, low
   output logic                            supplyFaultOe      // Fault pin enable
);

   localparam int unsigned NCONV = 4;
   localparam int unsigned MW    = LVL_W + 7;
   localparam int unsigned BW    = $clog2(BLANK_CYC3 + 1);
   localparam int unsigned FW    = $clog2(FILTER_CYCLES + 1);
   localparam dfm_addr_t CTRL_IDX [NCONV] = '{`DFM_IDX_CONV1_CTRL, `DFM_IDX_CONV2_CTRL,
                                               `DFM_IDX_CONV3_CTRL, `DFM_IDX_CONV4_CTRL};

   logic [3:0]    ovMeta;
   logic [3:0]    ovSync;
   logic [3:0]    rawFault;
   logic [3:0]    blanked;
   logic [3:0]    qualFault;
   logic [3:0]    qualPrev;
   logic [3:0]    uvSet;
   logic [3:0]    offSet;
   logic [3:0]    convOff;
   logic [3:0]    next_convEnable;
   logic          sysSet;
   logic [FW-1:0] filtCnt [NCONV];
   logic [BW-1:0] blankCnt [NCONV];
   logic [3:0]    uvStatus;
   logic [3:0]    uvMask;
   logic [3:0]    pinMask;
   logic [1:0]    blankSel;
   dfm_action_e   action [NCONV];
   logic          apbAccess;
   logic          apbDone;
   logic          addrHit;
   logic [31:0]   readMux;

   // Index to byte address
   function automatic dfm_addr_t regAddr(input dfm_addr_t idx);
      regAddr = {idx[9:0], 2'b00};
   endfunction

   // Compare against 95 percent without a divider
   function automatic logic isUnder(input logic [LVL_W-1:0] meas,
                                    input logic [LVL_W-1:0] tgt);
      logic [MW-1:0] m100;
      logic [MW-1:0] t95;
      m100 = MW'(meas) * MW'(`DFM_FULL_PCT);
      t95  = MW'(tgt) * MW'(`DFM_UV_PCT);
      isUnder = (m100 < t95);
   endfunction

   // Blanking length for the shared selector
   function automatic logic [BW-1:0] blankLoad(input logic [1:0] sel);
      case (sel)
         2'h0:    blankLoad = BW'(BLANK_CYC0);
         2'h1:    blankLoad = BW'(BLANK_CYC1);
         2'h2:    blankLoad = BW'(BLANK_CYC2);
         default: blankLoad = BW'(BLANK_CYC3);
      endcase
   endfunction

   // Overvoltage comes from analog comparators, so synchronise it
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ovMeta <= 4'h0;
         ovSync <= 4'h0;
      end else begin
         ovMeta <= convOverVoltAsync;
         ovSync <= ovMeta;
      end
   end

   // Per-converter fault qualification
   always_comb begin
      sysSet = 1'b0;
      for (int i = 0; i < NCONV; i++) begin
         rawFault[i]  = isUnder(convMeasLevel[i], convTargetLevel[i]) | ovSync[i];
         blanked[i]   = ~convEnable[i] | (blankCnt[i] != '0);
         qualFault[i] = (filtCnt[i] == FW'(FILTER_CYCLES)) & rawFault[i]
                        & ~blanked[i];
         uvSet[i]     = qualFault[i] & ~qualPrev[i];
         offSet[i]    = qualFault[i] & (action[i] == DFM_ACT_CONV_OFF);
         sysSet       = sysSet | (qualFault[i] & action[i][1]);
      end
      next_convEnable = convEnableReq & ~(convOff | offSet);
   end

   // Persistence counter, cleared by any gap or by blanking
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < NCONV; i++) begin
            filtCnt[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NCONV; i++) begin
            if (rawFault[i] & ~blanked[i]) begin
               if (filtCnt[i] != FW'(FILTER_CYCLES)) begin
                  filtCnt[i] <= filtCnt[i] + FW'(1);
               end
            end else begin
               filtCnt[i] <= '0;
            end
         end
      end
   end

   // Enables and start-up blanking; a restart reloads the timer
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         convEnable <= 4'h0;
         for (int i = 0; i < NCONV; i++) begin
            blankCnt[i] <= '0;
         end
      end else begin
         convEnable <= next_convEnable;
         for (int i = 0; i < NCONV; i++) begin
            if (next_convEnable[i] & ~convEnable[i]) begin
               blankCnt[i] <= blankLoad(blankSel);
            end else if (blankCnt[i] != '0) begin
               blankCnt[i] <= blankCnt[i] - BW'(1);
            end
         end
      end
   end

   // Converter stays off until the sequencer drops its request
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         convOff <= 4'h0;
      end else begin
         convOff <= offSet | (convOff & convEnableReq);
      end
   end

   // Shutdown request is sticky; only reset releases it
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sysShutdownReq <= 1'b0;
      end else if (sysSet) begin
         sysShutdownReq <= 1'b1;
      end
   end

   // Edge detector history for the status flags
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         qualPrev <= 4'h0;
      end else begin
         qualPrev <= qualFault;
      end
   end

   // APB handshake: one wait state so read data comes from a flop
   assign apbAccess = psel & penable;
   assign apbDone   = apbAccess & pready;

   // Read decode
   always_comb begin
      readMux = 32'h0000_0000;
      addrHit = 1'b1;
      if (paddr == regAddr(`DFM_IDX_UV_STATUS)) begin
         readMux[3:0] = uvStatus;
      end else if (paddr == regAddr(`DFM_IDX_UV_MASK)) begin
         readMux[3:0] = uvMask;
      end else if (paddr == regAddr(`DFM_IDX_ACTIVE_OPTS)) begin
         readMux[`DFM_BLANK_SEL_HI:`DFM_BLANK_SEL_LO] = blankSel;
      end else if (paddr == regAddr(`DFM_IDX_PIN_MASK)) begin
         readMux[3:0] = pinMask;
      end else if (paddr == regAddr(CTRL_IDX[0])) begin
         readMux[`DFM_ACTION_HI:`DFM_ACTION_LO] = action[0];
      end else if (paddr == regAddr(CTRL_IDX[1])) begin
         readMux[`DFM_ACTION_HI:`DFM_ACTION_LO] = action[1];
      end else if (paddr == regAddr(CTRL_IDX[2])) begin
         readMux[`DFM_ACTION_HI:`DFM_ACTION_LO] = action[2];
      end else if (paddr == regAddr(CTRL_IDX[3])) begin
         readMux[`DFM_ACTION_HI:`DFM_ACTION_LO] = action[3];
      end else begin
         addrHit = 1'b0;
      end
   end

   // Bus answer registers
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= apbAccess & ~pready;
         if (apbAccess & ~pready) begin
            prdata  <= pwrite ? 32'h0000_0000 : readMux;
            pslverr <= ~addrHit;
         end
      end
   end

   // Software-written configuration
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         uvMask   <= `DFM_RST_UV_MASK;
         pinMask  <= `DFM_RST_PIN_MASK;
         blankSel <= `DFM_RST_BLANK_SEL;
         for (int i = 0; i < NCONV; i++) begin
            action[i] <= dfm_action_e'(`DFM_RST_ACTION);
         end
      end else if (apbDone & pwrite) begin
         if (paddr == regAddr(`DFM_IDX_UV_MASK)) begin
            uvMask <= pwdata[3:0];
         end else if (paddr == regAddr(`DFM_IDX_ACTIVE_OPTS)) begin
            blankSel <= pwdata[`DFM_BLANK_SEL_HI:`DFM_BLANK_SEL_LO];
         end else if (paddr == regAddr(`DFM_IDX_PIN_MASK)) begin
            pinMask <= pwdata[3:0];
         end else begin
            for (int i = 0; i < NCONV; i++) begin
               if (paddr == regAddr(CTRL_IDX[i])) begin
                  action[i] <= dfm_action_e'(pwdata[`DFM_ACTION_HI:`DFM_ACTION_LO]);
               end
            end
         end
      end
   end

   // Status: clear only what the read returned, so a flag raised
   // during the wait state survives; a new edge always wins
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         uvStatus <= 4'h0;
      end else if (apbDone & ~pwrite & (paddr == regAddr(`DFM_IDX_UV_STATUS))) begin
         uvStatus <= (uvStatus & ~prdata[3:0]) | uvSet;
      end else begin
         uvStatus <= uvStatus | uvSet;
      end
   end

   // First-level interrupt and fault pin
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         supplyUndervoltIrq <= 1'b0;
         supplyFaultN       <= 1'b1;
         supplyFaultOe      <= 1'b0;
      end else begin
         supplyUndervoltIrq <= (|(uvStatus & ~uvMask)) | ldoUndervoltIrq;
         supplyFaultN       <= ~((|(qualFault & ~pinMask))
                                 | ldoFault | climFault);
         supplyFaultOe      <= faultPinAssign;
      end
   end

   property p_uv_cmp;
      @(posedge ref_clk) disable iff (sys_rst)
      rawFault[0] == ((20 * int'(convMeasLevel[0]) < 19 * int'(convTargetLevel[0]))
                      || ovSync[0]);
   endproperty
   a_uv_cmp: assert property (p_uv_cmp)
      else $error("Converter 1 fault without undervoltage");

   property p_conv_off;
      @(posedge ref_clk) disable iff (sys_rst)
      (qualFault[3] && action[3] == DFM_ACT_CONV_OFF) |=> !convEnable[3] [*2];
   endproperty
   a_conv_off: assert property (p_conv_off)
      else $error("Converter 4 not disabled after fault");

   property p_sys_off;
      @(posedge ref_clk) disable iff (sys_rst)
      (qualFault[3] && action[3][1]) |=> sysShutdownReq;
   endproperty
   a_sys_off: assert property (p_sys_off)
      else $error("No shutdown request after fault");

   property p_flag_set;
      @(posedge ref_clk) disable iff (sys_rst)
      $rose(qualFault[0]) |=> uvStatus[0];
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("Status flag not raised by fault");

   property p_read_clear;
      @(posedge ref_clk) disable iff (sys_rst)
      (apbDone && !pwrite && paddr == regAddr(`DFM_IDX_UV_STATUS) && uvSet == 4'h0)
      |=> ((uvStatus & $past(prdata[3:0])) == 4'h0);
   endproperty
   a_read_clear: assert property (p_read_clear)
      else $error("Status read did not clear flags");

   property p_irq_mask;
      @(posedge ref_clk) disable iff (sys_rst)
      (uvStatus[0] && !uvMask[0]) |=> supplyUndervoltIrq;
   endproperty
   a_irq_mask: assert property (p_irq_mask)
      else $error("Unmasked flag did not raise interrupt");

   property p_irq_quiet;
      @(posedge ref_clk) disable iff (sys_rst)
      ((uvStatus & ~uvMask) == 4'h0 && !ldoUndervoltIrq) |=> !supplyUndervoltIrq;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet)
      else $error("Interrupt without unmasked source");

   property p_pin_fault;
      @(posedge ref_clk) disable iff (sys_rst)
      (qualFault[0] && !pinMask[0]) |=> !supplyFaultN;
   endproperty
   a_pin_fault: assert property (p_pin_fault)
      else $error("Fault pin not low for unmasked converter");

   property p_pin_masked;
      @(posedge ref_clk) disable iff (sys_rst)
      ((qualFault & ~pinMask) == 4'h0 && !ldoFault && !climFault) |=> supplyFaultN;
   endproperty
   a_pin_masked: assert property (p_pin_masked)
      else $error("Fault pin low with all sources masked");

   property p_filter;
      @(posedge ref_clk) disable iff (sys_rst)
      $rose(qualFault[0]) |-> ($past(rawFault[0]) && !$past(blanked[0]));
   endproperty
   a_filter: assert property (p_filter)
      else $error("Fault qualified without persistence");

   property p_blank_load;
      @(posedge ref_clk) disable iff (sys_rst)
      $rose(convEnable[0]) |-> (blankCnt[0] == blankLoad($past(blankSel)));
   endproperty
   a_blank_load: assert property (p_blank_load)
      else $error("Blank timer not loaded at start");

   property p_ready;
      @(posedge ref_clk) disable iff (sys_rst)
      (apbAccess && !pready) |=> pready;
   endproperty
   a_ready: assert property (p_ready)
      else $error("APB access not answered");

endmodule

// ===== tb/dfm_host_pin_model.sv
`timescale 1ns/10ps

// Host view of the fault pin; the board pull-up holds it high when undriven
module dfm_host_pin_model (
   input  wire logic supplyFaultN,  // Pin level from device
   input  wire logic supplyFaultOe, // Device drives pin
   output logic      faultLine      // Level the host sees
);
   // Released pin floats up, never keeps its last value
   assign faultLine = supplyFaultOe ? supplyFaultN : 1'b1;
endmodule

// ===== tb/tb_dcdc_fault_monitor_irq.sv
`timescale 1ns/10ps
`include "dfm_defines.svh"

`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end

module tb_dcdc_fault_monitor_irq;
   import dfm_pkg::*;
   localparam int unsigned FILT = 3;
   localparam int unsigned BLK [4] = '{20, 40, 60, 80};
   logic                ref_clk = 0, sys_rst = 1;
   dfm_addr_t           paddr = '0;
   logic                psel = 0, penable = 0, pwrite = 0;
   logic [31:0]         pwdata = '0, prdata;
   logic                pready, pslverr;
   logic [3:0][7:0]     meas = {4{8'h64}}, tgt = {4{8'h64}};
   logic [3:0]          ovAsync = '0, enReq = '0, convEnable;
   logic                ldoIrq = 0, ldoFault = 0, climFault = 0, pinAssign = 1;
   logic                sysShutdownReq, supplyUndervoltIrq, supplyFaultN, supplyFaultOe;
   logic                faultLine;
   logic [32:0]         expQ [$];
   logic [32:0]         expNow;
   logic [31:0]         rnd;
   int                  mismatches = 0, checked = 0, lat [4], cnt;
   integer              seed = 80;
   dfm_addr_t           regAddr [7];
   logic [31:0]         regMsk [7];

   dfm_fault_monitor #(.LVL_W(8), .FILTER_CYCLES(FILT), .BLANK_CYC0(BLK[0]),
      .BLANK_CYC1(BLK[1]), .BLANK_CYC2(BLK[2]), .BLANK_CYC3(BLK[3])) u_dut (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .convMeasLevel(meas),
      .convTargetLevel(tgt), .convOverVoltAsync(ovAsync), .convEnableReq(enReq),
      .ldoUndervoltIrq(ldoIrq), .ldoFault(ldoFault), .climFault(climFault),
      .faultPinAssign(pinAssign), .convEnable(convEnable),
      .sysShutdownReq(sysShutdownReq), .supplyUndervoltIrq(supplyUndervoltIrq),
      .supplyFaultN(supplyFaultN), .supplyFaultOe(supplyFaultOe));

   dfm_host_pin_model u_host (.supplyFaultN(supplyFaultN), .supplyFaultOe(supplyFaultOe),
      .faultLine(faultLine));

   // Free running system clock
   always #4 ref_clk = ~ref_clk;

   function automatic dfm_addr_t ba(input int idx);
      return dfm_addr_t'(idx * 4);
   endfunction

   task automatic stop_test();
      $display("counts: checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic do_reset();
      @(posedge ref_clk) sys_rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
   endtask

   // One APB transfer; reads leave their expected answer in the queue
   task automatic apb(input dfm_addr_t a, input logic w, input logic [31:0] d,
                      input logic [32:0] e);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      if (!w) expQ.push_back(e);
      @(posedge ref_clk) penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge ref_clk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         mismatches++;
         stop_test();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Read answers are compared as they land on the bus
   always @(posedge ref_clk) begin
      if (psel && penable && !pwrite && pready === 1'b1) begin
         expNow = expQ.pop_front();
         `CHK({pslverr, prdata}, expNow)
      end
   end

   // Watchdog against a hang anywhere in the sequence
   initial begin
      #400us;
      mismatches++;
      stop_test();
   end

   initial begin
      regAddr = '{ba(`DFM_IDX_UV_MASK), ba(`DFM_IDX_PIN_MASK), ba(`DFM_IDX_ACTIVE_OPTS),
         ba(`DFM_IDX_CONV1_CTRL), ba(`DFM_IDX_CONV2_CTRL), ba(`DFM_IDX_CONV3_CTRL),
         ba(`DFM_IDX_CONV4_CTRL)};
      regMsk = '{32'h0000000f, 32'h0000000f, 32'h00003000, 32'h0000c000, 32'h0000c000,
         32'h0000c000, 32'h0000c000};
      do_reset();
      // Reset values, random readback, status not writable, unmapped refused
      for (int i = 0; i < 7; i++) begin
         rnd = $random(seed);
         apb(regAddr[i], 1'b0, '0, 33'h0);
         apb(regAddr[i], 1'b1, rnd, 'x);
         apb(regAddr[i], 1'b0, '0, {1'b0, rnd & regMsk[i]});
         apb(regAddr[i], 1'b1, 32'h0, 'x);
      end
      apb(ba(`DFM_IDX_UV_STATUS), 1'b1, 32'hf, 'x);
      apb(ba(`DFM_IDX_UV_STATUS), 1'b0, '0, 33'h0);
      apb(12'h004, 1'b0, '0, {1'b1, 32'h0});
      $display("test registers done");

      // Threshold boundary, filter glitch, then a held fault on converter 1
      @(posedge ref_clk) enReq <= 4'hf;
      cyc(BLK[0] + 10);
      // Target of 200 so the threshold follows the target, not a fixed level
      @(posedge ref_clk) {tgt[0], meas[0]} <= {8'd200, 8'd190};
      cyc(FILT + 6);
      `CHK(faultLine, 1'b1)
      @(posedge ref_clk) meas[0] <= 8'd189;
      repeat (FILT) @(posedge ref_clk);
      meas[0] <= 8'd200;
      cyc(FILT + 6);
      `CHK(supplyUndervoltIrq, 1'b0)
      apb(ba(`DFM_IDX_UV_STATUS), 1'b0, '0, 33'h0);
      @(posedge ref_clk) meas[0] <= 8'd189;
      cyc(FILT + 4);
      `CHK({supplyUndervoltIrq, faultLine, convEnable}, 6'h2f)
      apb(ba(`DFM_IDX_UV_STATUS), 1'b0, '0, 33'h1);
      apb(ba(`DFM_IDX_UV_STATUS), 1'b0, '0, 33'h0);
      cyc(2);
      `CHK(supplyUndervoltIrq, 1'b0)
      @(posedge ref_clk) {tgt[0], meas[0]} <= {8'd100, 8'd100};
      $display("test filter done");

      // Masked overvoltage, pin mask, LDO and current-limit sources
      apb(ba(`DFM_IDX_UV_MASK), 1'b1, 32'h4, 'x);
      @(posedge ref_clk) ovAsync[2] <= 1'b1;
      cyc(FILT + 8);
      `CHK(supplyUndervoltIrq, 1'b0)
      `CHK(faultLine, 1'b0)
      apb(ba(`DFM_IDX_PIN_MASK), 1'b1, 32'h4, 'x);
      cyc(3);
      `CHK(faultLine, 1'b1)
      apb(ba(`DFM_IDX_UV_STATUS), 1'b0, '0, 33'h4);
      @(posedge ref_clk) ldoIrq <= 1'b1;
      cyc(3);
      `CHK(supplyUndervoltIrq, 1'b1)
      @(posedge ref_clk) {ldoIrq, ldoFault} <= 2'b01;
      cyc(3);
      `CHK(faultLine, 1'b0)
      @(posedge ref_clk) {ldoFault, climFault} <= 2'b01;
      cyc(3);
      `CHK(faultLine, 1'b0)
      @(posedge ref_clk) {climFault, pinAssign} <= 2'b10;
      cyc(3);
      `CHK(faultLine, 1'b1)
      // Current-limit fault must be gone before the blanking latencies
      @(posedge ref_clk) {ovAsync, climFault, pinAssign} <= 6'h01;
      $display("test masks done");

      // Start-up blanking for each time select on converter 4
      @(posedge ref_clk) meas[3] <= 8'd94;
      for (int s = 0; s < 4; s++) begin
         apb(ba(`DFM_IDX_ACTIVE_OPTS), 1'b1, 32'(s) << 12, 'x);
         @(posedge ref_clk) enReq[3] <= 1'b0;
         cyc(FILT + 6);
         `CHK(faultLine, 1'b1)
         @(posedge ref_clk) enReq[3] <= 1'b1;
         for (cnt = 0; cnt < 400 && faultLine !== 1'b0; cnt++) cyc(1);
         if (cnt == 400) begin
            mismatches++;
            stop_test();
         end
         lat[s] = cnt;
         // Enable flop, blank time, filter length, then the pin flop
         `CHK(lat[s], int'(BLK[s]) + int'(FILT) + 2)
      end
      @(posedge ref_clk) meas[3] <= 8'd100;
      $display("test blanking done");

      // Every fault action on converter 4, each from a fresh reset
      for (int a = 0; a < 4; a++) begin
         do_reset();
         apb(ba(`DFM_IDX_CONV4_CTRL), 1'b1, 32'(a) << 14, 'x);
         cyc(BLK[0] + 10);
         @(posedge ref_clk) meas[3] <= 8'd94;
         cyc(FILT + 6);
         `CHK(sysShutdownReq, a[1])
         `CHK(convEnable[3], a != 1)
         `CHK(supplyUndervoltIrq, 1'b1)
         apb(ba(`DFM_IDX_UV_STATUS), 1'b0, '0, 33'h8);
         @(posedge ref_clk) meas[3] <= 8'd100;
      end
      $display("test actions done");
      stop_test();
   end
endmodule
